// >>> hdl/adsrc_top.v
// converter sequence control, result placement and register bus slave
//
// Notes on behaviour
// - any write to sequence_control with sel_i[0] set aborts the running sequence and starts nothing.
// - the four length bits give 1 to 15 conversions, and code zero means 16.
// - reset sets only the weight-four length bit, for a default of 4 conversions.
// - with wrap mode clear the nth result lands in the nth result register.
// - with wrap mode set the counter is not reset at sequence end or at a scan restart, and results go to consecutive registers.
// - in wrap mode the counter returns to register zero after the last register.
// - the conversion counter is readable in the status register.
// - an abort or a restart by a control write clears the counter, even in wrap mode.
// - debug_halt_select picks run on, reserved, finish then halt, or halt at once.
// - each result register has its own conversion-complete flag.
`include "adsrc_consts.vh"

module adsrc_top (
    input  wire                     clk_i,
    input  wire                     rst_i,
    input  wire                     cyc_i,
    input  wire                     stb_i,
    input  wire                     we_i,
    input  wire [7:0]               adr_i,
    input  wire [3:0]               sel_i,
    input  wire [31:0]              dat_i,
    output reg  [31:0]              dat_o,
    output reg                      ack_o,
    input  wire                     freeze_i,
    input  wire [`ADSRC_RES_W-1:0]  sample_i,
    output wire                     conv_busy_o,
    output wire                     irq_o
);

    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_GAP  = 2'h2;

    reg  [7:0]                seq_ctl_r;
    reg                       scan_r;
    reg  [1:0]                state_r;
    reg  [1:0]                state_nxt;
    reg  [`ADSRC_CNT_W-1:0]   cnt_r;
    reg  [`ADSRC_CNT_W-1:0]   cnt_nxt;
    reg  [`ADSRC_LEN_W-1:0]   done_r;
    reg  [`ADSRC_LEN_W-1:0]   done_nxt;
    reg                       seq_end;
    reg  [`ADSRC_IRQ_W-1:0]   irq_stat_r;
    reg  [`ADSRC_IRQ_W-1:0]   irq_mask_r;
    reg  [31:0]               rd_word;

    wire [`ADSRC_ADR_W-1:0]   idx;
    wire                      req;
    wire                      wr_stb;
    wire                      rd_stb;
    wire                      wr_seq;
    wire                      wr_start;
    wire                      res_hit;
    wire [`ADSRC_LEN_W-1:0]   seq_len;
    wire                      wrap_mode;
    wire [1:0]                frz_sel;
    wire                      halt_now;
    wire                      halt_next;
    wire                      conv_start;
    wire                      conv_done;
    wire                      conv_busy;
    wire [`ADSRC_RES_W-1:0]   conv_result;
    wire [`ADSRC_RES_W-1:0]   res_rd_data;
    wire [`ADSRC_RES_N-1:0]   ccf;
    wire [`ADSRC_IRQ_W-1:0]   irq_set;
    wire                      restart;

    ////////////////////////////////////////////////////////////////////
    // bus decode: one aligned word per register, writes need the low byte lane, reads ignore sel_i
    assign idx      = adr_i[7:2];
    assign req      = cyc_i && stb_i && !ack_o;
    assign wr_stb   = req && we_i && sel_i[0];
    assign rd_stb   = req && !we_i;
    assign wr_seq   = wr_stb && (idx == `ADSRC_IDX_SEQ_CTL);
    assign wr_start = wr_stb && (idx == `ADSRC_IDX_START);
    assign res_hit  = (idx[5:4] == `ADSRC_IDX_RES_BASE);

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control fields
    assign seq_len = (seq_ctl_r[`ADSRC_SEQ_LEN_HI:`ADSRC_SEQ_LEN_LO] ==
                      {`ADSRC_CNT_W{1'b0}}) ? `ADSRC_LEN_FULL :
                     {1'b0, seq_ctl_r[`ADSRC_SEQ_LEN_HI:`ADSRC_SEQ_LEN_LO]};
    assign wrap_mode = seq_ctl_r[`ADSRC_SEQ_WRAP];
    assign frz_sel   = seq_ctl_r[`ADSRC_SEQ_FRZ_HI:`ADSRC_SEQ_FRZ_LO];

    // breakpoint is on this clock already; reserved code falls through
    assign halt_now  = freeze_i && (frz_sel == `ADSRC_FRZ_NOW);
    assign halt_next = freeze_i &&
                       (frz_sel == `ADSRC_FRZ_FINISH ||
                        frz_sel == `ADSRC_FRZ_NOW);

    // both control writes end the current sequence at once
    assign restart = wr_seq || wr_start;

    always @(posedge clk_i) begin
        if (rst_i) begin
            seq_ctl_r <= `ADSRC_SEQ_RESET;
            scan_r    <= 1'b0;
        end else begin
            if (wr_seq) begin
                seq_ctl_r <= dat_i[7:0] & `ADSRC_SEQ_MASK;
            end
            if (wr_start) begin
                scan_r <= dat_i[`ADSRC_START_SCAN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer
    assign conv_start = (state_r == ST_RUN) && !conv_busy && !conv_done &&
                        !halt_next && !restart;

    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        done_nxt  = done_r;
        seq_end   = 1'b0;
        if (restart) begin
            cnt_nxt   = {`ADSRC_CNT_W{1'b0}};
            done_nxt  = {`ADSRC_LEN_W{1'b0}};
            state_nxt = wr_start ? ST_RUN : ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                ST_RUN, ST_GAP: begin
                    state_nxt = ST_RUN;
                    if (conv_done) begin
                        // 4-bit counter rolls from 15 to 0 by itself
                        cnt_nxt  = cnt_r + {{(`ADSRC_CNT_W-1){1'b0}}, 1'b1};
                        done_nxt = done_r + {{(`ADSRC_LEN_W-1){1'b0}}, 1'b1};
                        if (done_nxt == seq_len) begin
                            seq_end  = 1'b1;
                            done_nxt = {`ADSRC_LEN_W{1'b0}};
                            if (!wrap_mode) begin
                                cnt_nxt = {`ADSRC_CNT_W{1'b0}};
                            end
                            state_nxt = scan_r ? ST_GAP : ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cnt_r   <= {`ADSRC_CNT_W{1'b0}};
            done_r  <= {`ADSRC_LEN_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            done_r  <= done_nxt;
        end
    end

    adsrc_conv_unit u_conv (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (conv_start),
        .abort_i  (restart),
        .halt_i   (halt_now),
        .sample_i (sample_i),
        .busy_o   (conv_busy),
        .done_o   (conv_done),
        .result_o (conv_result)
    );

    assign conv_busy_o = conv_busy;

    // result goes where the counter points: nth in nth, or next in wrap
    adsrc_result_file u_res (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_i      (conv_done && !restart),
        .wr_idx_i  (cnt_r),
        .wr_data_i (conv_result),
        .rd_i      (rd_stb && res_hit),
        .rd_idx_i  (idx[3:0]),
        .clr_all_i (wr_start),
        .rd_data_o (res_rd_data),
        .ccf_o     (ccf)
    );

    ////////////////////////////////////////////////////////////////////
    // interrupts: sticky, write one to clear, set beats clear
    assign irq_set = {conv_done && !restart, seq_end};

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= {`ADSRC_IRQ_W{1'b0}};
            irq_mask_r <= {`ADSRC_IRQ_W{1'b0}};
        end else begin
            if (wr_stb && idx == `ADSRC_IDX_IRQ_MASK) begin
                irq_mask_r <= dat_i[`ADSRC_IRQ_W-1:0];
            end
            if (wr_stb && idx == `ADSRC_IDX_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~dat_i[`ADSRC_IRQ_W-1:0]) |
                              irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped words read zero and still acknowledge
    always @* begin
        rd_word = 32'h0000_0000;
        if (res_hit) begin
            rd_word[`ADSRC_RES_W-1:0] = res_rd_data;
        end else begin
            case (idx)
                `ADSRC_IDX_SEQ_CTL: begin
                    rd_word[7:0] = seq_ctl_r;
                end
                `ADSRC_IDX_START: begin
                    rd_word[`ADSRC_START_SCAN] = scan_r;
                end
                `ADSRC_IDX_STATUS: begin
                    rd_word[3:0] = cnt_r;
                    rd_word[4]   = (state_r != ST_IDLE);
                    rd_word[5]   = conv_busy;
                end
                `ADSRC_IDX_IRQ_STAT: begin
                    rd_word[`ADSRC_IRQ_W-1:0] = irq_stat_r;
                end
                `ADSRC_IDX_IRQ_MASK: begin
                    rd_word[`ADSRC_IRQ_W-1:0] = irq_mask_r;
                end
                `ADSRC_IDX_CCF: begin
                    rd_word[`ADSRC_RES_N-1:0] = ccf;
                end
                default: begin
                    rd_word = 32'h0000_0000;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_stb) begin
            dat_o <= rd_word;
        end
    end

endmodule

// >>> hdl/adsrc_consts.vh
// constants for the converter sequence and result control block
`ifndef ADSRC_CONSTS_VH
`define ADSRC_CONSTS_VH

// register indices; byte address is four times the index
`define ADSRC_IDX_SEQ_CTL    6'h03
`define ADSRC_IDX_START      6'h05
`define ADSRC_IDX_STATUS     6'h06
`define ADSRC_IDX_IRQ_STAT   6'h07
`define ADSRC_IDX_IRQ_MASK   6'h08
`define ADSRC_IDX_CCF        6'h09
`define ADSRC_IDX_RES_BASE   2'h1
`define ADSRC_ADR_W          6

// sequence_control fields
`define ADSRC_SEQ_RESET      8'h20
`define ADSRC_SEQ_LEN_HI     6
`define ADSRC_SEQ_LEN_LO     3
`define ADSRC_SEQ_WRAP       2
`define ADSRC_SEQ_FRZ_HI     1
`define ADSRC_SEQ_FRZ_LO     0
`define ADSRC_SEQ_MASK       8'h7f

// conversion_start_control fields
`define ADSRC_START_SCAN     0

// debug_halt_select codes
`define ADSRC_FRZ_RUN        2'h0
`define ADSRC_FRZ_RSVD       2'h1
`define ADSRC_FRZ_FINISH     2'h2
`define ADSRC_FRZ_NOW        2'h3

// interrupt status bits
`define ADSRC_IRQ_SEQ_DONE   0
`define ADSRC_IRQ_CONV_DONE  1
`define ADSRC_IRQ_W          2

// sequence lengths and sizes
`define ADSRC_LEN_FULL       5'h10
`define ADSRC_LEN_W          5
`define ADSRC_CNT_W          4
`define ADSRC_RES_N          16
`define ADSRC_RES_W          10

// conversion time in bus clocks
`define ADSRC_CONV_CYC       6'h20
`define ADSRC_CONV_CNT_W     6

`endif

// >>> hdl/adsrc_conv_unit.v
// one conversion at a time: timing, halt and result capture
`include "adsrc_consts.vh"

module adsrc_conv_unit (
    input  wire                     clk_i,
    input  wire                     rst_i,
    input  wire                     start_i,
    input  wire                     abort_i,
    input  wire                     halt_i,
    input  wire [`ADSRC_RES_W-1:0]  sample_i,
    output wire                     busy_o,
    output reg                      done_o,
    output reg  [`ADSRC_RES_W-1:0]  result_o
);

    reg [`ADSRC_RES_W-1:0]      samp_meta_r;
    reg [`ADSRC_RES_W-1:0]      samp_sync_r;
    reg [`ADSRC_CONV_CNT_W-1:0] cnt_r;
    reg                         busy_r;

    assign busy_o = busy_r;

    ////////////////////////////////////////////////////////////////////
    // converter output comes from outside the clock domain
    always @(posedge clk_i) begin
        if (rst_i) begin
            samp_meta_r <= {`ADSRC_RES_W{1'b0}};
            samp_sync_r <= {`ADSRC_RES_W{1'b0}};
        end else begin
            samp_meta_r <= sample_i;
            samp_sync_r <= samp_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // a halted conversion keeps its count and resumes where it stopped
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r    <= {`ADSRC_CONV_CNT_W{1'b0}};
            busy_r   <= 1'b0;
            done_o   <= 1'b0;
            result_o <= {`ADSRC_RES_W{1'b0}};
        end else begin
            done_o <= 1'b0;
            if (abort_i) begin
                busy_r <= 1'b0;
                cnt_r  <= {`ADSRC_CONV_CNT_W{1'b0}};
            end else if (start_i && !busy_r) begin
                busy_r <= 1'b1;
                cnt_r  <= `ADSRC_CONV_CYC;
            end else if (busy_r && !halt_i) begin
                if (cnt_r == {{(`ADSRC_CONV_CNT_W-1){1'b0}}, 1'b1}) begin
                    busy_r   <= 1'b0;
                    done_o   <= 1'b1;
                    result_o <= samp_sync_r;
                end
                cnt_r <= cnt_r - {{(`ADSRC_CONV_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// >>> hdl/adsrc_result_file.v
// result registers with one conversion-complete flag each
`include "adsrc_consts.vh"

module adsrc_result_file (
    input  wire                     clk_i,
    input  wire                     rst_i,
    input  wire                     wr_i,
    input  wire [`ADSRC_CNT_W-1:0]  wr_idx_i,
    input  wire [`ADSRC_RES_W-1:0]  wr_data_i,
    input  wire                     rd_i,
    input  wire [`ADSRC_CNT_W-1:0]  rd_idx_i,
    input  wire                     clr_all_i,
    output wire [`ADSRC_RES_W-1:0]  rd_data_o,
    output wire [`ADSRC_RES_N-1:0]  ccf_o
);

    reg  [`ADSRC_RES_W-1:0] mem_r [0:`ADSRC_RES_N-1];
    wire [`ADSRC_RES_N-1:0] ccf_w;
    integer                 i;

    assign rd_data_o = mem_r[rd_idx_i];
    assign ccf_o     = ccf_w;

    // one process owns the whole array, so each entry has one driver
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < `ADSRC_RES_N; i = i + 1) begin
                mem_r[i] <= {`ADSRC_RES_W{1'b0}};
            end
        end else if (wr_i) begin
            mem_r[wr_idx_i] <= wr_data_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `ADSRC_RES_N; g = g + 1) begin : g_ent
            wire hit_wr = wr_i && (wr_idx_i == g);
            wire hit_rd = rd_i && (rd_idx_i == g);
            reg  flag_r;
            assign ccf_w[g] = flag_r;
            always @(posedge clk_i) begin
                if (rst_i) begin
                    flag_r <= 1'b0;
                end else begin
                    // a new result wins over a read or restart clear
                    if (hit_wr) begin
                        flag_r <= 1'b1;
                    end else if (hit_rd || clr_all_i) begin
                        flag_r <= 1'b0;
                    end
                end
            end
        end
    endgenerate

endmodule

// >>> bench/adsrc_top_props.sv
// checker: bus handshake, control shadow, abort and freeze properties
module adsrc_top_props (
    input logic        clk_i,
    input logic        rst_i,
    input logic        cyc_i,
    input logic        stb_i,
    input logic        we_i,
    input logic [7:0]  adr_i,
    input logic [3:0]  sel_i,
    input logic [31:0] dat_i,
    input logic [31:0] dat_o,
    input logic        ack_o,
    input logic        freeze_i,
    input logic [9:0]  sample_i,
    input logic        conv_busy_o,
    input logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [6:0] seq_r;
    logic [1:0] msk_r;
    logic       idle_r;
    wire        wr   = cyc_i & stb_i & ~ack_o & we_i & sel_i[0];
    wire        rdak = ack_o & cyc_i & ~we_i;
    wire [5:0]  idx  = adr_i[7:2];
    ////////////////////////////////////////////////////////////////////
    // shadow of what software wrote; bad-sel writes are ignored
    always @(posedge clk_i) begin
        if (rst_i) begin
            seq_r  <= 7'h20;
            msk_r  <= 2'h0;
            idle_r <= 1'b1;
        end else if (wr) begin
            if (idx == 6'h03) seq_r <= dat_i[6:0];
            if (idx == 6'h08) msk_r <= dat_i[1:0];
            if (idx == 6'h03) idle_r <= 1'b1;
            if (idx == 6'h05) idle_r <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> s_ack_pulse)
        else $error("ack not a one cycle pulse after request");
    AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    AST_SEQ_RD: assert property (rdak && idx == 6'h03 |-> dat_o == {25'h0, seq_r})
        else $error("sequence control read mismatch");
    AST_ABORT: assert property (wr && idx == 6'h03 |=> !conv_busy_o [*4])
        else $error("conversion runs after control write");
    AST_QUIET_STATUS: assert property (rdak && idx == 6'h06 && idle_r |-> dat_o[5:0] == 6'h00)
        else $error("status not clear after abort");
    AST_FRZ_HOLD: assert property (seq_r[1:0] == 2'h3 && freeze_i && conv_busy_o && !wr |=> conv_busy_o)
        else $error("immediate halt lost busy");
    AST_FRZ_NOSTART: assert property (seq_r[1] && freeze_i && !conv_busy_o && !wr |=> !conv_busy_o)
        else $error("conversion started while halted");
    AST_IRQ_MASKED: assert property (msk_r == 2'h0 |-> !irq_o)
        else $error("interrupt with all sources masked");
endmodule

bind adsrc_top adsrc_top_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .freeze_i(freeze_i),
    .sample_i(sample_i), .conv_busy_o(conv_busy_o), .irq_o(irq_o)
);

// >>> bench/test_adc_sequence_result_control.sv
// self-checking bench for the sequence and result control block
module test_adc_sequence_result_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        cyc_i    = 1'b0;
    logic        stb_i    = 1'b0;
    logic        we_i     = 1'b0;
    logic        freeze_i = 1'b0;
    logic [7:0]  adr_i    = 8'h00;
    logic [3:0]  sel_i    = 4'h0;
    logic [31:0] dat_i    = 32'h0;
    logic [9:0]  sample_i = 10'h2a5;
    wire  [31:0] dat_o;
    wire         ack_o;
    wire         conv_busy_o;
    wire         irq_o;
    int          err_count   = 0;
    int          check_count = 0;
    int          cyc_cnt     = 0;
    logic [31:0] q;
    logic [1:0]  c;

    adsrc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .freeze_i(freeze_i),
        .sample_i(sample_i), .conv_busy_o(conv_busy_o), .irq_o(irq_o));

    initial forever #2 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // holds the request until ack is sampled high, then releases it
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(q, e);
    endtask

    // polls the sequence-done flag at most 400 times, then checks that it is set
    task automatic wait_seq;
        q = 32'h0;
        for (int i = 0; i < 400 && q[0] !== 1'b1; i++)
            bus(1'b0, 8'h1c, 32'h0, 4'hf);
        chk({31'h0, q[0]}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h0c, 32'h20);
        wr(8'h0c, 32'hff);
        rd(8'h0c, 32'h7f);
        bus(1'b1, 8'h0c, 32'h20, 4'h0);
        rd(8'h0c, 32'h7f);
        rd(8'h00, 32'h0);
        // fixed placement, two conversions, single sequence
        wr(8'h0c, 32'h10);
        wr(8'h14, 32'h0);
        wait_seq();
        rd(8'h24, 32'h3);
        rd(8'h18, 32'h0);
        rd(8'h44, {22'h0, sample_i});
        rd(8'h24, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        wr(8'h20, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wr(8'h1c, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        wr(8'h20, 32'h0);
        // wrap mode, three per sequence, scanning
        wr(8'h0c, 32'h1c);
        wr(8'h14, 32'h1);
        wait_seq();
        wr(8'h1c, 32'h1);
        wait_seq();
        bus(1'b0, 8'h18, 32'h0, 4'hf);
        chk({28'h0, q[3:0]}, 32'h6);
        rd(8'h24, 32'h3f);
        wr(8'h14, 32'h1);
        bus(1'b0, 8'h18, 32'h0, 4'hf);
        chk({28'h0, q[3:0]}, 32'h0);
        wr(8'h0c, 32'h1c);
        rd(8'h18, 32'h0);
        repeat (40) @(posedge clk_i);
        rd(8'h18, 32'h0);
        // wrap mode, length code zero, counter passes the last register
        wr(8'h1c, 32'h3);
        wr(8'h0c, 32'h04);
        wr(8'h14, 32'h1);
        wait_seq();
        bus(1'b0, 8'h18, 32'h0, 4'hf);
        chk({28'h0, q[3:0]}, 32'h0);
        rd(8'h24, 32'hffff);
        wr(8'h0c, 32'h00);
        // breakpoint during the first of two conversions, every code
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            wr(8'h0c, {27'h0, 2'h2, 1'b0, c});
            wr(8'h14, 32'h0);
            repeat (10) @(posedge clk_i);
            freeze_i <= 1'b1;
            repeat (100) @(posedge clk_i);
            rd(8'h24, (c == 2'h3) ? 32'h0 : (c == 2'h2) ? 32'h1 : 32'h3);
            freeze_i <= 1'b0;
            repeat (100) @(posedge clk_i);
            rd(8'h24, 32'h3);
        end
        stop_test();
    end
endmodule
